// file: dv/hbc_chk.sv
`default_nettype none
module hbc_chk (
   // clock and reset
   input wire logic        hclk,
   input wire logic        hresetn,
   // device side
   input wire logic        chip_select_n,
   input wire logic        mem_reg_select,
   input wire logic [16:0] byte_address_inputs,
   input wire logic        data_lanes_oe,
   input wire logic        low_read_strobe_n,
   input wire logic        high_read_strobe_n,
   input wire logic        bus_status_n,
   // processor-side mirror
   input wire logic        transfer_begin_strobe_n,
   input wire logic        transfer_done_ack_n,
   input wire logic        cycle_active_flag,
   input wire logic        read_write,
   input wire logic [1:0]  transfer_kind_code
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////
   chk_begin_pulse: assert property (
      $fell(transfer_begin_strobe_n) |=> transfer_begin_strobe_n) else $error("begin too long");
   chk_flag_held: assert property (
      !chip_select_n |-> cycle_active_flag) else $error("flag low in cycle");
   chk_ack_pulse: assert property (
      $fell(transfer_done_ack_n) |=> transfer_done_ack_n) else $error("ack too long");
   chk_ack_gap: assert property (
      $fell(transfer_done_ack_n) |=> transfer_begin_strobe_n [*2]) else $error("start after ack");
   chk_min_len: assert property (
      $fell(transfer_begin_strobe_n) |-> transfer_done_ack_n [*2]) else $error("cycle too short");
   chk_dir_match: assert property (
      !chip_select_n |-> read_write == !low_read_strobe_n) else $error("direction wrong");
   chk_kind_normal: assert property (
      !transfer_begin_strobe_n |-> transfer_kind_code == hbc_pkg::HBC_KIND_NORM)
      else $error("kind not normal");
   chk_write_lanes: assert property (
      !chip_select_n && !read_write |-> data_lanes_oe && low_read_strobe_n && high_read_strobe_n)
      else $error("write lanes wrong");
   chk_read_lanes: assert property (
      !chip_select_n && read_write |-> !data_lanes_oe && !low_read_strobe_n && !high_read_strobe_n)
      else $error("read strobes wrong");
   chk_addr_hold: assert property (
      !chip_select_n && $past(!chip_select_n) |-> $stable(byte_address_inputs)
      && $stable(mem_reg_select)) else $error("address moved");
   chk_status_high: assert property (
      bus_status_n) else $error("bus status low");
   // main scenarios seen
   cover property ($fell(transfer_done_ack_n) && read_write);
   cover property ($fell(transfer_done_ack_n) && !read_write);
   cover property (!chip_select_n [*8]);
endmodule
bind hbc_host hbc_chk u_chk (.hclk, .hresetn, .chip_select_n, .mem_reg_select,
   .byte_address_inputs, .data_lanes_oe, .low_read_strobe_n, .high_read_strobe_n, .bus_status_n,
   .transfer_begin_strobe_n, .transfer_done_ack_n, .cycle_active_flag, .read_write,
   .transfer_kind_code);
`default_nettype wire

// file: dv/hbc_dev_model.sv
`default_nettype none
module hbc_dev_model (
   // clock and reset from host
   input wire logic        clk,
   input wire logic        rst_n,
   // address, select, strobes
   input wire logic [16:0] addr,
   input wire logic        mrs,
   input wire logic        cs_n,
   input wire logic        we_lo_n,
   input wire logic        we_hi_n,
   input wire logic        rd_lo_n,
   input wire logic        rd_hi_n,
   input wire logic [15:0] dq_o,
   // straps and wait
   input wire logic [3:0]  mode,
   input wire logic        order,
   input wire logic        pol,
   input var  int          dly,
   output logic            stall,
   output logic     [15:0] dq_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [2][64];
   logic [15:0] dq_hold;
   logic [16:0] last_a;
   logic [3:0]  mode_l;
   logic        order_l, pol_l, cs_q;
   int          cnt, acc, early;
   // straps sampled as reset releases
   always @(posedge rst_n) begin
      mode_l <= mode;
      order_l <= order;
      pol_l <= pol;
   end
   // wait until arbitration done; idle shows not ready
   always_comb stall = (!cs_n && cnt >= dly) ? pol_l : !pol_l;
   // undriven lanes toggle so stale data never matches
   always_comb dq_i = (!cs_n && !rd_lo_n && !rd_hi_n && cnt >= dly) ?
      mem[mrs][addr[6:1]] : ~dq_hold;
   always_ff @(posedge clk) dq_hold <= dq_i;
   // access counting, byte writes into register or memory block
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         cs_q <= 1'b1;
         acc <= 0;
         early <= 0;
      end else begin
         cs_q <= cs_n;
         cnt <= cs_n ? 0 : cnt + 1;
         if (!cs_n && cs_q) begin
            acc <= acc + 1;
            last_a <= addr;
         end
         if (cs_n && !cs_q && cnt < dly) early <= early + 1;
         if (!cs_n && cnt >= dly && !we_lo_n) mem[mrs][addr[6:1]][7:0] <= dq_o[7:0];
         if (!cs_n && cnt >= dly && !we_hi_n) mem[mrs][addr[6:1]][15:8] <= dq_o[15:8];
      end
   end
endmodule
`default_nettype wire

// file: dv/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
   wire         hrdy, hresp, bclk, drst_n, mrs, cs_n, oe, wl_n, wh_n, rl_n, rh_n, bs_n, ord;
   wire         pol, stall;
   wire  [3:0]  mode;
   wire  [16:0] ba;
   wire  [15:0] dq_i, dq_o;
   wire  [31:0] hrdata;
   int          err_total = 0, num_checks = 0, dly = 0, a0;
   hbc_host dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready(hrdy),
      .hwdata, .hrdata, .hreadyout(hrdy), .hresp, .host_bus_clock(bclk), .dev_reset_n(drst_n),
      .byte_address_inputs(ba), .mem_reg_select(mrs), .chip_select_n(cs_n), .data_lanes_in(dq_i),
      .data_lanes_out(dq_o), .data_lanes_oe(oe), .low_byte_write_strobe_n(wl_n),
      .high_byte_write_strobe_n(wh_n), .low_read_strobe_n(rl_n), .high_read_strobe_n(rh_n),
      .bus_status_n(bs_n), .stall_in(stall), .bus_mode_straps(mode), .byte_order_strap(ord),
      .stall_polarity_strap(pol), .transfer_begin_strobe_n(), .transfer_done_ack_n(),
      .cycle_active_flag(), .read_write(), .size_byte_write_lines(), .transfer_kind_code(),
      .host_data_out());
   hbc_dev_model u_dev (.clk(bclk), .rst_n(drst_n), .addr(ba), .mrs, .cs_n, .we_lo_n(wl_n),
      .we_hi_n(wh_n), .rd_lo_n(rl_n), .rd_hi_n(rh_n), .dq_o, .mode, .order(ord), .pol, .dly,
      .stall, .dq_i);
   always #10 hclk = ~hclk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // bounded wait for the slave's ready at a rising edge
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin @(posedge hclk); n++; end while (hrdy !== 1'b1 && n < 50);
      if (n >= 50) begin err_total++; close_out; end
   endtask
   // one single word transfer, read data taken at the data phase edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      wait_rdy;
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy;
      q = hrdata;
   endtask
   task automatic go(input logic rd, mm, lo, hi, input logic [16:0] a, input logic [15:0] d);
      ahb(1'b1, hbc_pkg::HBC_ADDR_OFS, {15'h0, a});
      ahb(1'b1, hbc_pkg::HBC_WDATA_OFS, {16'h0, d});
      ahb(1'b1, hbc_pkg::HBC_CTRL_OFS, {27'h0, mm, hi, lo, rd, 1'b1});
   endtask
   // poll until idle; read data lands in q
   task automatic fin(input logic rd);
      int n;
      n = 0;
      do begin ahb(1'b0, hbc_pkg::HBC_STATUS_OFS, 32'h0); n++; end while (q[0] !== 1'b0 && n < 80);
      if (n >= 80) begin err_total++; close_out; end
      chk("done", {31'h0, q[1]}, 32'h1);
      if (rd) ahb(1'b0, hbc_pkg::HBC_RDATA_OFS, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic sc_straps;
      ahb(1'b0, hbc_pkg::HBC_STRAP_OFS, 32'h0);
      chk("strap reg", q, 32'h3b);
      chk("mode seen", {28'h0, u_dev.mode_l}, 32'hb);
      chk("wait pol", {31'h0, u_dev.pol_l}, 32'h1);
      chk("order", {31'h0, u_dev.order_l}, 32'h1);
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask
   // lane writes in both blocks, then read back; stall raised on second pass
   task automatic sc_lanes(input int d);
      dly = d;
      go(1'b0, 1'b0, 1'b1, 1'b1, 17'h00012, 16'h5a3c); fin(1'b0);
      go(1'b0, 1'b1, 1'b1, 1'b1, 17'h00012, 16'hc0de); fin(1'b0);
      go(1'b0, 1'b1, 1'b1, 1'b0, 17'h00012, 16'h7711); fin(1'b0);
      go(1'b0, 1'b1, 1'b0, 1'b1, 17'h00012, 16'h9988); fin(1'b0);
      go(1'b1, 1'b1, 1'b1, 1'b1, 17'h00012, 16'h0000); fin(1'b1);
      chk("mem word", {16'h0, q[15:0]}, 32'h9911);
      go(1'b1, 1'b0, 1'b1, 1'b1, 17'h00012, 16'h0000); fin(1'b1);
      chk("reg word", {16'h0, q[15:0]}, 32'h5a3c);
      chk("early end", u_dev.early, 32'h0);
   endtask
   // second go and address write while busy must be dropped
   task automatic sc_busy;
      dly = 20;
      a0 = u_dev.acc;
      go(1'b0, 1'b1, 1'b1, 1'b1, 17'h1fffe, 16'h1234);
      ahb(1'b1, hbc_pkg::HBC_ADDR_OFS, 32'h00055);
      ahb(1'b1, hbc_pkg::HBC_CTRL_OFS, 32'h00000013);
      fin(1'b0);
      chk("accesses", u_dev.acc, a0 + 1);
      chk("address", {15'h0, u_dev.last_a}, 32'h1fffe);
      ahb(1'b0, 8'h20, 32'h0);
      chk("unmapped", q, 32'h0);
   endtask
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      sc_straps;
      sc_lanes(0);
      sc_lanes(6);
      sc_busy;
      close_out;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      err_total++;
      close_out;
   end
endmodule
`default_nettype wire

// file: rtl/hbc_host.sv
// The register offsets and the AHB-Lite register port were decided locally.
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// How it works
// - start strobe low one cycle, address presented
// - direction high on reads, low writes
// - size lines and kind code with address
// - cycle active flag held whole cycle
// - no new cycle until acknowledge released
// - transaction lasts at least two clocks
// - only normal cycles, never bursts
// - 17-bit byte address on low lines
// - big endian byte lane placement
// - select low only during our accesses
// - lane write strobes low per byte
// - both read strobes low on reads
// - bus status held permanently high
// - select configured: 16-bit, external ack, no burst
module hbc_host (
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // device clock and reset
   output logic             host_bus_clock,
   output logic             dev_reset_n,
   // device address and select
   output logic      [16:0] byte_address_inputs,
   output logic             mem_reg_select,
   output logic             chip_select_n,
   // device data lanes, two-way
   input  wire logic [15:0] data_lanes_in,
   output logic      [15:0] data_lanes_out,
   output logic             data_lanes_oe,
   // device strobes
   output logic             low_byte_write_strobe_n,
   output logic             high_byte_write_strobe_n,
   output logic             low_read_strobe_n,
   output logic             high_read_strobe_n,
   output logic             bus_status_n,
   input  wire logic        stall_in,
   // straps driven to device
   output logic      [3:0]  bus_mode_straps,
   output logic             byte_order_strap,
   output logic             stall_polarity_strap,
   // processor-side bus mirror
   output logic             transfer_begin_strobe_n,
   output logic             transfer_done_ack_n,
   output logic             cycle_active_flag,
   output logic             read_write,
   output logic      [1:0]  size_byte_write_lines,
   output logic      [1:0]  transfer_kind_code,
   output logic      [31:0] host_data_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // operating notes
   //
   // software side
   //  - one ahb-lite slave, never stretched: hreadyout tied high
   //  - every register is one aligned word; only the low address byte decodes
   //  - register writes are dropped while a transfer is in flight, so
   //    address, data and lanes of a running cycle cannot change under it
   //  - a go while busy is dropped as well; software polls the busy bit
   //  - unmapped reads return zero, unmapped writes vanish
   //
   // device side
   //  - the device runs on our own clock, so only its wait pin is foreign
   //  - the wait pin passes two flops; this costs two cycles per transfer
   //    but keeps a late pin edge from splitting the sequencer decision
   //  - select, strobes and address are all registered, glitch free
   //  - the first pin cycle already carries the new command's lanes and
   //    direction, taken straight from the control word being written
   //  - single normal cycles only; the kind code is fixed, bursts never leave
   //
   // reset and straps
   //  - straps stand at their register values while the device reset is low
   //  - device reset trails ours by one clock so straps are settled first
   //  - a strap write moves the strap pins at once, but the block reset reloads the reset values, so no latch ever sees it
   //  - wait polarity is latched in step with the device's own latch
   //
   // timing of one transfer
   //  - cycle 0: control word with go written, sequencer leaves idle
   //  - cycle 1: begin strobe low, select and strobes low, flag high
   //  - then: wait for the synchronised ready level and two cycles counted
   //  - ack cycle: select and strobes released, ack pulse low one clock
   //  - one gap cycle follows, then idle; a new go is taken only there
   //
   // limitations
   //  - no byte steering for odd addresses: lanes come straight from control
   //  - read data land only in the low half of the read data register
   //  - the mirror outputs describe the cycle, they drive nothing themselves
   ////////////////////////////////////////////////////////////////////////////////

   // sequencer state
   hbc_pkg::hbc_state_t state_r;
   // ahb address phase copy
   logic        ph_valid_r;
   logic        ph_write_r;
   logic [7:0]  ph_addr_r;
   // software registers
   logic [31:0] ctrl_r;
   logic [16:0] addr_r;
   logic [15:0] wdata_r;
   logic [15:0] rdata_r;
   logic        done_r;
   logic        pol_r;
   logic [5:0]  strap_r;
   // transfer timing
   logic [1:0]  cyc_cnt_r;
   // wait pin synchroniser
   logic        stall_s1_r;
   logic        stall_s2_r;
   // decoded events
   logic        go_wr;
   logic        ack_now;

   ////////////////////////////////////////////////////////////////////////////////
   // ahb address phase capture; slave always ready, okay response
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid_r <= 1'b0;
         ph_write_r <= 1'b0;
         ph_addr_r  <= 8'h00;
      end else if (hready) begin
         ph_valid_r <= hsel && htrans[1];
         ph_write_r <= hwrite;
         ph_addr_r  <= haddr[7:0];
      end
   end
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   assign go_wr = ph_valid_r && ph_write_r && (ph_addr_r == hbc_pkg::HBC_CTRL_OFS)
                  && hwdata[hbc_pkg::HBC_CTRL_GO_BIT] && (state_r == hbc_pkg::HBC_IDLE);

   // software registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r  <= hbc_pkg::HBC_WORD_RST;
         addr_r  <= hbc_pkg::HBC_ADDR_RST;
         wdata_r <= hbc_pkg::HBC_DATA_RST;
         strap_r <= {hbc_pkg::HBC_POL_STRAP_RST, hbc_pkg::HBC_ORDER_STRAP_RST,
                     hbc_pkg::HBC_MODE_STRAP_RST};
      end else if (ph_valid_r && ph_write_r && state_r == hbc_pkg::HBC_IDLE) begin
         case (ph_addr_r)
            hbc_pkg::HBC_CTRL_OFS:  ctrl_r  <= hwdata;
            hbc_pkg::HBC_ADDR_OFS:  addr_r  <= hwdata[16:0];
            hbc_pkg::HBC_WDATA_OFS: wdata_r <= hwdata[15:0];
            hbc_pkg::HBC_STRAP_OFS: strap_r <= hwdata[5:0];
            default: ;
         endcase
      end
   end

   // read mux; unmapped reads as zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= hbc_pkg::HBC_WORD_RST;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         case (haddr[7:0])
            hbc_pkg::HBC_CTRL_OFS:   hrdata <= {27'h0, ctrl_r[4:0]};
            hbc_pkg::HBC_ADDR_OFS:   hrdata <= {15'h0, addr_r};
            hbc_pkg::HBC_WDATA_OFS:  hrdata <= {16'h0, wdata_r};
            hbc_pkg::HBC_RDATA_OFS:  hrdata <= {16'h0, rdata_r};
            hbc_pkg::HBC_STATUS_OFS: hrdata <= {24'h0, strap_r, done_r,
                                                state_r != hbc_pkg::HBC_IDLE};
            hbc_pkg::HBC_STRAP_OFS:  hrdata <= {26'h0, strap_r};
            default:                 hrdata <= hbc_pkg::HBC_WORD_RST;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // device shares our clock; straps stand while device reset is low
   assign host_bus_clock       = hclk;
   assign bus_mode_straps      = strap_r[3:0];
   assign byte_order_strap     = strap_r[4];
   assign stall_polarity_strap = strap_r[5];
   assign bus_status_n         = 1'b1;

   // device reset held low one cycle after ours so straps settle first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) dev_reset_n <= 1'b0;
      else          dev_reset_n <= 1'b1;
   end

   // polarity latched after release, matching what the device latched
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)          pol_r <= hbc_pkg::HBC_POL_STRAP_RST;
      else if (!dev_reset_n) pol_r <= strap_r[5];
   end

   // wait from device pin, two flops before use
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stall_s1_r <= 1'b0;
         stall_s2_r <= 1'b0;
      end else begin
         stall_s1_r <= stall_in;
         stall_s2_r <= stall_s1_r;
      end
   end
   // active-high sense: pin high means ready; active-low sense: pin low means ready
   assign ack_now = (pol_r ? stall_s2_r : !stall_s2_r) && (cyc_cnt_r >= hbc_pkg::HBC_MIN_CYC);

   ////////////////////////////////////////////////////////////////////////////////
   // transfer sequencer; single normal cycles only, bursts never issued
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= hbc_pkg::HBC_IDLE;
      end else begin
         case (state_r)
            hbc_pkg::HBC_IDLE:  if (go_wr) state_r <= hbc_pkg::HBC_START;
            hbc_pkg::HBC_START: state_r <= hbc_pkg::HBC_WAIT;
            hbc_pkg::HBC_WAIT:  if (ack_now) state_r <= hbc_pkg::HBC_DONE;
            hbc_pkg::HBC_DONE:  state_r <= hbc_pkg::HBC_GAP;
            hbc_pkg::HBC_GAP:   state_r <= hbc_pkg::HBC_IDLE;
            default:            state_r <= hbc_pkg::HBC_IDLE;
         endcase
      end
   end

   // cycles since start, saturating
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)                          cyc_cnt_r <= 2'h0;
      else if (state_r == hbc_pkg::HBC_IDLE) cyc_cnt_r <= 2'h0;
      else if (cyc_cnt_r != 2'h3)            cyc_cnt_r <= cyc_cnt_r + 2'h1;
   end

   // done flag: set wins over clear by new go
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)                              done_r <= 1'b0;
      else if (state_r == hbc_pkg::HBC_DONE)     done_r <= 1'b1;
      else if (go_wr)                            done_r <= 1'b0;
   end

   // read capture, lanes stored straight with no byte swap, read back in the low half
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_r <= hbc_pkg::HBC_DATA_RST;
      end else if (state_r == hbc_pkg::HBC_WAIT && ack_now && ctrl_r[hbc_pkg::HBC_CTRL_RD_BIT]) begin
         rdata_r <= data_lanes_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin drivers, all registered
   logic active_nxt;
   logic rd;
   logic lo;
   logic hi;
   // fresh control word on the go cycle; the stored copy would
   // replay the previous command's lanes on the first strobe cycle
   assign rd = go_wr ? hwdata[hbc_pkg::HBC_CTRL_RD_BIT] : ctrl_r[hbc_pkg::HBC_CTRL_RD_BIT];
   assign lo = go_wr ? hwdata[hbc_pkg::HBC_CTRL_LO_BIT] : ctrl_r[hbc_pkg::HBC_CTRL_LO_BIT];
   assign hi = go_wr ? hwdata[hbc_pkg::HBC_CTRL_HI_BIT] : ctrl_r[hbc_pkg::HBC_CTRL_HI_BIT];
   assign active_nxt = (state_r == hbc_pkg::HBC_IDLE && go_wr)
                    || state_r == hbc_pkg::HBC_START
                    || (state_r == hbc_pkg::HBC_WAIT && !ack_now);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chip_select_n            <= 1'b1;
         transfer_begin_strobe_n  <= 1'b1;
         cycle_active_flag        <= 1'b0;
         low_byte_write_strobe_n  <= 1'b1;
         high_byte_write_strobe_n <= 1'b1;
         low_read_strobe_n        <= 1'b1;
         high_read_strobe_n       <= 1'b1;
         data_lanes_oe            <= 1'b0;
         transfer_done_ack_n      <= 1'b1;
      end else begin
         chip_select_n            <= !active_nxt;
         transfer_begin_strobe_n  <= !(state_r == hbc_pkg::HBC_IDLE && go_wr);
         cycle_active_flag        <= active_nxt;
         low_byte_write_strobe_n  <= !(active_nxt && !rd && lo);
         high_byte_write_strobe_n <= !(active_nxt && !rd && hi);
         low_read_strobe_n        <= !(active_nxt && rd);
         high_read_strobe_n       <= !(active_nxt && rd);
         data_lanes_oe            <= active_nxt && !rd;
         transfer_done_ack_n      <= !(state_r == hbc_pkg::HBC_WAIT && ack_now);
      end
   end

   // address and data held from the register copies; select and direction from the control word being written
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         byte_address_inputs   <= hbc_pkg::HBC_ADDR_RST;
         mem_reg_select        <= 1'b0;
         read_write            <= 1'b1;
         size_byte_write_lines <= hbc_pkg::HBC_SIZE_16;
         transfer_kind_code    <= hbc_pkg::HBC_KIND_NORM;
         data_lanes_out        <= hbc_pkg::HBC_DATA_RST;
         host_data_out         <= hbc_pkg::HBC_WORD_RST;
      end else if (go_wr) begin
         byte_address_inputs   <= addr_r;
         mem_reg_select        <= hwdata[hbc_pkg::HBC_CTRL_MEM_BIT];
         read_write            <= hwdata[hbc_pkg::HBC_CTRL_RD_BIT];
         size_byte_write_lines <= (hwdata[hbc_pkg::HBC_CTRL_LO_BIT] && hwdata[hbc_pkg::HBC_CTRL_HI_BIT])
                                  ? hbc_pkg::HBC_SIZE_16 : hbc_pkg::HBC_SIZE_8;
         transfer_kind_code    <= hbc_pkg::HBC_KIND_NORM;
         data_lanes_out        <= wdata_r;
         host_data_out         <= {wdata_r, 16'h0000};
      end
   end

endmodule
`default_nettype wire

// file: rtl/hbc_pkg.sv
`default_nettype none
package hbc_pkg;
   // software register map of the controller, byte addresses
   localparam logic [7:0] HBC_CTRL_OFS   = 8'h00; // go bit, direction, lanes, space
   localparam logic [7:0] HBC_ADDR_OFS   = 8'h04; // 17-bit byte address
   localparam logic [7:0] HBC_WDATA_OFS  = 8'h08; // 16-bit write data
   localparam logic [7:0] HBC_RDATA_OFS  = 8'h0c; // 16-bit read data
   localparam logic [7:0] HBC_STATUS_OFS = 8'h10; // busy, done, strap view
   localparam logic [7:0] HBC_STRAP_OFS  = 8'h14; // strap pin levels, back to defaults at reset
   // control field positions
   localparam int HBC_CTRL_GO_BIT  = 0;
   localparam int HBC_CTRL_RD_BIT  = 1;
   localparam int HBC_CTRL_LO_BIT  = 2;
   localparam int HBC_CTRL_HI_BIT  = 3;
   localparam int HBC_CTRL_MEM_BIT = 4;
   // status field positions
   localparam int HBC_STAT_BUSY_BIT = 0;
   localparam int HBC_STAT_DONE_BIT = 1;
   // strap reset values: big endian byte-enable mode, active-high ready
   localparam logic [3:0] HBC_MODE_STRAP_RST  = 4'hb;
   localparam logic       HBC_ORDER_STRAP_RST = 1'b1;
   localparam logic       HBC_POL_STRAP_RST   = 1'b1;
   // reset values
   localparam logic [31:0] HBC_WORD_RST  = 32'h0000_0000;
   localparam logic [16:0] HBC_ADDR_RST  = 17'h0_0000;
   localparam logic [15:0] HBC_DATA_RST  = 16'h0000;
   // least cycles from start strobe to acknowledge
   localparam logic [1:0]  HBC_MIN_CYC   = 2'h2;
   // transfer size codes on the size lines (16-bit port)
   localparam logic [1:0]  HBC_SIZE_16   = 2'h2;
   localparam logic [1:0]  HBC_SIZE_8    = 2'h1;
   // normal access transfer kind
   localparam logic [1:0]  HBC_KIND_NORM = 2'h0;
   // controller sequencer states
   typedef enum logic [4:0] {
      HBC_IDLE  = 5'b00001,
      HBC_START = 5'b00010,
      HBC_WAIT  = 5'b00100,
      HBC_DONE  = 5'b01000,
      HBC_GAP   = 5'b10000
   } hbc_state_t;
endpackage
`default_nettype wire
